// file: bench/tb_vector_flags_trap_and_length_ctrl.sv
module tb_vector_flags_trap_and_length_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic sys_clk, srst, reg_wr, reg_rd, flag_req, unpredicated, is_cterm, cterm_n, cterm_v;
    logic fp_req, fp_is_half, fp_is_conv, fp_denorm, fp_active, fp_exc_in, trap_req;
    logic pair_req, prefix_changed_state, prefix_abort, prefixed_abort, irq_req;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, prefix_addr, prefixed_addr, instr_start_addr, rd;
    logic [31:0] restart_addr, fault_address_reg;
    logic [255:0] test_pred, gov_pred;
    logic [1:0] elem_size, cur_el;
    logic [3:0] flags_nzcv;
    logic active_not_last_test, last_or_none_test, termination_absent_test;
    logic termination_present_test, fp_flush_en, fp_alt_fmt_eff, fp_exc_raise;
    logic input_denormal_sticky, trap_raise;
    logic [5:0] syndrome_class_field;
    logic [4:0] eff_len_quanta;
    int bad_count, check_count, i;
    typedef struct packed {
        logic [1:0] es;
        logic [3:0] mode;
        logic [255:0] tp;
        logic [255:0] gp;
        logic [3:0] nzcv;
        logic [3:0] tests;
    } vftlc_row_t;
    vftlc_row_t rows [7];
    logic [7:0] tr [10];
    logic [8:0] pr [5];
    logic [31:0] av [4];
    logic [11:0] lc [8];
    logic [1:0] le [8];
    logic [4:0] lq [8];

    // ----------------------------------------------------------------
    // Design
    // ----------------------------------------------------------------
    vftlc_core vftlc_core_i (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .flag_req, .test_pred, .gov_pred, .elem_size, .unpredicated, .is_cterm,
        .cterm_n, .cterm_v, .flags_nzcv, .active_not_last_test, .last_or_none_test,
        .termination_absent_test, .termination_present_test, .fp_req, .fp_is_half,
        .fp_is_conv, .fp_denorm, .fp_active, .fp_exc_in, .fp_flush_en, .fp_alt_fmt_eff,
        .fp_exc_raise, .input_denormal_sticky, .trap_req, .cur_el, .trap_raise,
        .syndrome_class_field, .pair_req, .prefix_changed_state, .prefix_addr, .prefixed_addr,
        .prefix_abort, .prefixed_abort, .irq_req, .instr_start_addr, .restart_addr,
        .fault_address_reg, .eff_len_quanta);

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic fp_op(input logic [4:0] v, input logic [3:0] exp);
        @(posedge sys_clk);
        {fp_is_half, fp_is_conv, fp_denorm, fp_active, fp_exc_in} <= v;
        fp_req <= 1'b1;
        @(posedge sys_clk);
        fp_req <= 1'b0;
        #1;
        chk("fp_out", 32'(exp), 32'({fp_flush_en, fp_alt_fmt_eff, fp_exc_raise,
            input_denormal_sticky}));
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        close_out();
    end

    initial
    begin
        srst = 1'b1;
        {reg_wr, reg_rd, flag_req, fp_req, trap_req, pair_req, irq_req} = '0;
        {unpredicated, is_cterm, cterm_n, cterm_v, prefix_changed_state} = '0;
        {fp_is_half, fp_is_conv, fp_denorm, fp_active, fp_exc_in} = '0;
        {prefix_abort, prefixed_abort, elem_size, cur_el} = '0;
        {reg_addr, reg_wdata, test_pred, gov_pred} = '0;
        prefix_addr = 32'h0000_1000;
        prefixed_addr = 32'h0000_1004;
        instr_start_addr = 32'h0000_2000;
        av = '{32'h0000_0000, 32'h0000_1000, 32'h0000_1004, 32'h0000_2000};
        rows = '{'{2'h1, 4'h0, 256'hBBFA, 256'hABFE, 4'h0, 4'h6},
            '{2'h0, 4'h3, 256'h0003, 256'h0006, 4'hA, 4'h9},
            '{2'h0, 4'h0, '1, 256'h0, 4'h6, 4'h6},
            '{2'h3, 4'h8, 256'h1 << 248, 256'h0, 4'h0, 4'h6},
            '{2'h0, 4'h7, '1, '1, 4'h9, 4'h6},
            '{2'h0, 4'h5, 256'h0, '1, 4'h7, 4'h5},
            '{2'h0, 4'h8, 256'h0, 256'h0, 4'h6, 4'h6}};
        tr = '{8'h60, 8'hC0, 8'h41, 8'hA1, 8'h29, 8'h09, 8'hAB, 8'hDB, 8'h5D, 8'h3F};
        pr = '{9'h090, 9'h15A, 9'h0B6, 9'h1A1, 9'h139};
        lc = '{12'hFFF, 12'hF5F, 12'hF5F, 12'h2FF, 12'hFF6, 12'hF0F, 12'h777, 12'hFFE};
        le = '{2'h3, 2'h2, 2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h1};
        lq = '{5'h10, 5'h04, 5'h10, 5'h02, 5'h04, 5'h01, 5'h08, 5'h08};
        cur_el = 2'h3;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        #1 chk("eff_len_quanta", 32'h0000_0010, 32'(eff_len_quanta));
        chk("tests_rst", 32'h0000_0006, 32'({active_not_last_test, last_or_none_test,
            termination_absent_test, termination_present_test}));
        reg_read(8'h08);
        chk("lenctl", 32'h0000_0FFF, rd);
        reg_read(8'h20);
        chk("unmapped", 32'h0000_0000, rd);
        for (i = 0; i < 7; i++)
        begin
            @(posedge sys_clk);
            {unpredicated, is_cterm, cterm_n, cterm_v} <= rows[i].mode;
            elem_size <= rows[i].es;
            test_pred <= rows[i].tp;
            gov_pred <= rows[i].gp;
            flag_req <= 1'b1;
            @(posedge sys_clk);
            flag_req <= 1'b0;
            #1 chk("flags_nzcv", 32'(rows[i].nzcv),
                32'(flags_nzcv));
            chk("cond_tests", 32'(rows[i].tests), 32'({active_not_last_test, last_or_none_test,
                termination_absent_test, termination_present_test}));
        end
        reg_write(8'h00, 32'h0000_0006);
        fp_op(5'b10011, 4'b0010);
        reg_write(8'h00, 32'h0000_0001);
        fp_op(5'b10110, 4'b1000);
        fp_op(5'b10001, 4'b1000);
        fp_op(5'b11110, 4'b0001);
        reg_write(8'h0C, 32'h0000_0010);
        reg_read(8'h0C);
        chk("sticky_clear", 32'h0000_0000, 32'(rd[4]));
        reg_write(8'h00, 32'h0000_0006);
        fp_op(5'b00011, 4'b1110);
        for (i = 0; i < 10; i++)
        begin
            reg_write(8'h04, 32'(tr[i][4:0]));
            @(posedge sys_clk);
            cur_el <= tr[i][6:5];
            trap_req <= 1'b1;
            @(posedge sys_clk);
            trap_req <= 1'b0;
            #1 chk("trap_raise", 32'(tr[i][7]), 32'(trap_raise));
        end
        chk("syndrome", 32'h0000_0019, 32'(syndrome_class_field));
        reg_write(8'h10, 32'h0000_0000);
        reg_read(8'h10);
        chk("syndrome_reg", 32'h0000_0019, rd);
        for (i = 0; i < 5; i++)
        begin
            @(posedge sys_clk);
            {pair_req, prefix_changed_state, prefix_abort, prefixed_abort, irq_req} <= pr[i][4:0];
            @(posedge sys_clk);
            {pair_req, irq_req} <= 2'b00;
            #1 chk("restart_addr", av[pr[i][8:7]], restart_addr);
            chk("fault_addr", av[pr[i][6:5]], fault_address_reg);
        end
        for (i = 0; i < 8; i++)
        begin
            reg_write(8'h08, 32'(lc[i]));
            @(posedge sys_clk);
            cur_el <= le[i];
            repeat (2) @(posedge sys_clk);
            #1 chk("eff_len_quanta", 32'(lq[i]), 32'(eff_len_quanta));
        end
        reg_read(8'h08);
        chk("lenctl_kept", 32'h0000_0FFE, rd);
        reg_read(8'h0C);
        chk("status_eff", 32'h0000_0008, 32'(rd[12:8]));
        close_out();
    end
endmodule

// file: rtl/vftlc_core.sv
`include "vftlc_defs.svh"

module vftlc_core
    import vftlc_pkg::*;
#(
    parameter int PRED_W = `VFTLC_LEN_MAX_BITS / 8,
    parameter int MAX_Q = `VFTLC_LEN_MAX_BITS / `VFTLC_LEN_QUANTUM
)
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic flag_req,
    input wire logic [PRED_W-1:0] test_pred,
    input wire logic [PRED_W-1:0] gov_pred,
    input wire logic [1:0] elem_size,
    input wire logic unpredicated,
    input wire logic is_cterm,
    input wire logic cterm_n,
    input wire logic cterm_v,
    output logic [3:0] flags_nzcv,
    output logic active_not_last_test,
    output logic last_or_none_test,
    output logic termination_absent_test,
    output logic termination_present_test,
    input wire logic fp_req,
    input wire logic fp_is_half,
    input wire logic fp_is_conv,
    input wire logic fp_denorm,
    input wire logic fp_active,
    input wire logic fp_exc_in,
    output logic fp_flush_en,
    output logic fp_alt_fmt_eff,
    output logic fp_exc_raise,
    output logic input_denormal_sticky,
    input wire logic trap_req,
    input wire logic [1:0] cur_el,
    output logic trap_raise,
    output logic [5:0] syndrome_class_field,
    input wire logic pair_req,
    input wire logic prefix_changed_state,
    input wire logic [31:0] prefix_addr,
    input wire logic [31:0] prefixed_addr,
    input wire logic prefix_abort,
    input wire logic prefixed_abort,
    input wire logic irq_req,
    input wire logic [31:0] instr_start_addr,
    output logic [31:0] restart_addr,
    output logic [31:0] fault_address_reg,
    output logic [4:0] eff_len_quanta
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    vftlc_state_t st_reg;
    vftlc_state_t st_next;
    logic [PRED_W-1:0] gov_eff;
    logic [PRED_W-1:0] act_true;
    logic [PRED_W-1:0] act_any;
    logic first_true;
    logic last_true;
    logic n_f;
    logic z_f;
    logic c_f;
    logic v_f;
    logic half_op;
    logic trapped;
    logic [4:0] req_q;
    logic [4:0] round_q;

    // ----------------------------------------------------------------
    // Predicate flag evaluation
    // ----------------------------------------------------------------
    always_comb
    begin
        gov_eff = unpredicated ? {PRED_W{1'b1}} : gov_pred;
        first_true = 1'b0;
        last_true = 1'b0;
        for (int i = 0; i < PRED_W; i++)
        begin
            // Only the lowest bit of each element is examined.
            act_any[i] = gov_eff[i] && ((i % (1 << elem_size)) == 0);
            act_true[i] = act_any[i] && test_pred[i];
        end
        for (int i = PRED_W - 1; i >= 0; i--)
        begin
            if (act_any[i])
            begin
                first_true = test_pred[i];
            end
        end
        for (int i = 0; i < PRED_W; i++)
        begin
            if (act_any[i])
            begin
                last_true = test_pred[i];
            end
        end
        n_f = is_cterm ? cterm_n : first_true;
        z_f = ~|act_true;
        c_f = ~last_true;
        v_f = is_cterm ? cterm_v : 1'b0;
    end

    // ----------------------------------------------------------------
    // Trap decision and effective length
    // ----------------------------------------------------------------
    always_comb
    begin
        trapped = 1'b0;
        if (cur_el != 2'd3 && !st_reg.trapctl[`VFTLC_TR_TOP_EN])
        begin
            trapped = 1'b1;
        end
        if (cur_el < 2'd3)
        begin
            if (st_reg.trapctl[`VFTLC_TR_HOST_EXT])
            begin
                trapped = trapped || !st_reg.trapctl[`VFTLC_TR_HYP_HOST_EN];
            end
            else
            begin
                trapped = trapped || st_reg.trapctl[`VFTLC_TR_HYP_TRAP];
            end
        end
        if (cur_el < 2'd2 && !st_reg.trapctl[`VFTLC_TR_KERN_EN])
        begin
            trapped = 1'b1;
        end
        req_q = 5'(MAX_Q);
        if (5'(st_reg.len3) + 5'd1 < req_q)
        begin
            req_q = 5'(st_reg.len3) + 5'd1;
        end
        if (cur_el != 2'd3 && 5'(st_reg.len2) + 5'd1 < req_q)
        begin
            req_q = 5'(st_reg.len2) + 5'd1;
        end
        if (cur_el < 2'd2 && 5'(st_reg.len1) + 5'd1 < req_q)
        begin
            req_q = 5'(st_reg.len1) + 5'd1;
        end
        round_q = 5'd1;
        for (int b = 0; b < 5; b++)
        begin
            if (req_q[b])
            begin
                round_q = 5'(1 << b);
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.rdata = 32'h0000_0000;
        st_next.trap_raise = 1'b0;
        st_next.fp_exc = 1'b0;
        st_next.eff_q = round_q;
        half_op = fp_is_half && !fp_is_conv;
        if (flag_req)
        begin
            st_next.nzcv = {n_f, z_f, c_f, v_f};
            st_next.cond_more = c_f && !z_f;
            st_next.cond_last = !c_f || z_f;
            st_next.cond_termination_absent_test = (n_f == v_f);
            st_next.cond_termination_present_test = (n_f != v_f);
        end
        if (fp_req)
        begin
            if (half_op)
            begin
                st_next.flush_en = st_reg.fpctl[`VFTLC_FP_HALF_FLUSH];
            end
            else
            begin
                st_next.flush_en = st_reg.fpctl[`VFTLC_FP_SD_FLUSH];
            end
            st_next.alt_fmt_eff = fp_is_half ? 1'b0 : st_reg.fpctl[`VFTLC_FP_ALT_FMT];
            st_next.fp_exc = fp_exc_in && fp_active;
        end
        if (reg_wr && reg_addr == `VFTLC_OFS_STATUS && reg_wdata[`VFTLC_ST_IDC])
        begin
            st_next.idc = 1'b0;
        end
        if (fp_req && fp_active && fp_denorm
            && !(half_op && st_reg.fpctl[`VFTLC_FP_HALF_FLUSH]))
        begin
            st_next.idc = 1'b1;
        end
        if (trap_req && trapped)
        begin
            st_next.trap_raise = 1'b1;
            st_next.syndrome = `VFTLC_SYND_CLASS;
        end
        if (irq_req)
        begin
            st_next.restart_addr = instr_start_addr;
        end
        if (pair_req)
        begin
            st_next.restart_addr = prefix_changed_state ? prefixed_addr : prefix_addr;
            if (prefix_abort)
            begin
                st_next.fault_addr = prefix_addr;
            end
            else if (prefixed_abort)
            begin
                st_next.fault_addr = prefixed_addr;
            end
        end
        if (reg_wr)
        begin
            case (reg_addr)
                `VFTLC_OFS_FPCTL: st_next.fpctl = reg_wdata[2:0];
                `VFTLC_OFS_TRAPCTL: st_next.trapctl = reg_wdata[4:0];
                `VFTLC_OFS_LENCTL:
                begin
                    st_next.len1 = reg_wdata[3:0];
                    st_next.len2 = reg_wdata[7:4];
                    st_next.len3 = reg_wdata[11:8];
                end
                default: st_next.fpctl = st_next.fpctl;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `VFTLC_OFS_FPCTL: st_next.rdata = {29'h0, st_reg.fpctl};
                `VFTLC_OFS_TRAPCTL: st_next.rdata = {27'h0, st_reg.trapctl};
                `VFTLC_OFS_LENCTL: st_next.rdata = {20'h0, st_reg.len3, st_reg.len2, st_reg.len1};
                `VFTLC_OFS_STATUS: st_next.rdata = {19'h0, st_reg.eff_q, 3'h0, st_reg.idc,
                    st_reg.nzcv};
                `VFTLC_OFS_SYND: st_next.rdata = {26'h0, st_reg.syndrome};
                `VFTLC_OFS_RESTART: st_next.rdata = st_reg.restart_addr;
                `VFTLC_OFS_FAULT: st_next.rdata = st_reg.fault_addr;
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
            st_reg.nzcv <= 4'h0;
            st_reg.cond_last <= 1'b1;
            st_reg.cond_termination_absent_test <= 1'b1;
            st_reg.fpctl <= `VFTLC_FPCTL_RST;
            st_reg.trapctl <= `VFTLC_TRAPCTL_RST;
            st_reg.len1 <= `VFTLC_LEN_RST;
            st_reg.len2 <= `VFTLC_LEN_RST;
            st_reg.len3 <= `VFTLC_LEN_RST;
            st_reg.eff_q <= 5'd1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = st_reg.rdata;
    assign flags_nzcv = st_reg.nzcv;
    assign active_not_last_test = st_reg.cond_more;
    assign last_or_none_test = st_reg.cond_last;
    assign termination_absent_test = st_reg.cond_termination_absent_test;
    assign termination_present_test = st_reg.cond_termination_present_test;
    assign fp_flush_en = st_reg.flush_en;
    assign fp_alt_fmt_eff = st_reg.alt_fmt_eff;
    assign fp_exc_raise = st_reg.fp_exc;
    assign input_denormal_sticky = st_reg.idc;
    assign trap_raise = st_reg.trap_raise;
    assign syndrome_class_field = st_reg.syndrome;
    assign restart_addr = st_reg.restart_addr;
    assign fault_address_reg = st_reg.fault_addr;
    assign eff_len_quanta = st_reg.eff_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_both_abort;
        pair_req && prefix_abort && prefixed_abort;
    endsequence

    sequence s_only_prefixed;
        pair_req && !prefix_abort && prefixed_abort;
    endsequence

    a_v_cleared: assert property (flag_req && !is_cterm |=> !flags_nzcv[0])
        else $error("overflow not cleared");
    a_zero_none: assert property (flag_req && unpredicated && test_pred == '0 && !is_cterm
        |=> flags_nzcv[2] && flags_nzcv[1] && !flags_nzcv[3])
        else $error("zero or carry wrong for empty result");
    a_no_active: assert property (flag_req && !unpredicated && gov_pred == '0 && !is_cterm
        |=> flags_nzcv == 4'b0110)
        else $error("flags wrong with no active element");
    a_more_test: assert property (active_not_last_test
        == (flags_nzcv[1] && !flags_nzcv[2]))
        else $error("more test mismatch");
    a_last_test: assert property (last_or_none_test
        == (!flags_nzcv[1] || flags_nzcv[2]))
        else $error("last test mismatch");
    a_term_test: assert property (termination_absent_test == (flags_nzcv[3] == flags_nzcv[0])
        && termination_present_test != termination_absent_test)
        else $error("termination test mismatch");
    a_alt_half: assert property (fp_req && fp_is_half |=> !fp_alt_fmt_eff)
        else $error("alternative format used for half");
    a_idc_half: assert property (fp_req && fp_is_half && !fp_is_conv && !input_denormal_sticky
        && st_reg.fpctl[`VFTLC_FP_HALF_FLUSH] |=> !input_denormal_sticky)
        else $error("denormal sticky set by half flush");
    a_exc_inactive: assert property (fp_req && !fp_active |=> !fp_exc_raise)
        else $error("exception from inactive element");
    a_trap_class: assert property ($rose(trap_raise)
        |-> syndrome_class_field == 6'b011001)
        else $error("wrong exception class");
    a_trap_el3: assert property (trap_req && cur_el == 2'h3 |=> !trap_raise)
        else $error("trap raised at top level");
    a_top_trap: assert property (trap_req && cur_el != 2'h3
        && !st_reg.trapctl[`VFTLC_TR_TOP_EN] |=> trap_raise)
        else $error("top level enable not applied");
    a_fault_both: assert property (s_both_abort
        |=> fault_address_reg == $past(prefix_addr))
        else $error("fault address not prefix");
    a_fault_pfx: assert property (s_only_prefixed
        |=> fault_address_reg == $past(prefixed_addr))
        else $error("fault address not prefixed");
    a_restart_pfx: assert property (pair_req && !prefix_changed_state
        |=> restart_addr == $past(prefix_addr))
        else $error("restart address not prefix");
    a_len_pow2: assert property ((eff_len_quanta & (eff_len_quanta - 5'd1)) == 5'd0
        && eff_len_quanta != 5'd0)
        else $error("length not a power of two");

endmodule

// file: rtl/vftlc_defs.svh
`ifndef VFTLC_DEFS_SVH
`define VFTLC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VFTLC_OFS_FPCTL 8'h00
`define VFTLC_OFS_TRAPCTL 8'h04
`define VFTLC_OFS_LENCTL 8'h08
`define VFTLC_OFS_STATUS 8'h0C
`define VFTLC_OFS_SYND 8'h10
`define VFTLC_OFS_RESTART 8'h14
`define VFTLC_OFS_FAULT 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VFTLC_FP_HALF_FLUSH 0
`define VFTLC_FP_SD_FLUSH 1
`define VFTLC_FP_ALT_FMT 2
`define VFTLC_TR_TOP_EN 0
`define VFTLC_TR_HYP_TRAP 1
`define VFTLC_TR_HYP_HOST_EN 2
`define VFTLC_TR_KERN_EN 3
`define VFTLC_TR_HOST_EXT 4
`define VFTLC_ST_IDC 4
`define VFTLC_ST_EFF_LSB 8

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define VFTLC_FPCTL_RST 3'h0
`define VFTLC_TRAPCTL_RST 5'h00
`define VFTLC_LEN_RST 4'hF
`define VFTLC_SYND_CLASS 6'b011001
`define VFTLC_LEN_QUANTUM 128
`define VFTLC_LEN_MAX_BITS 2048

`endif

// file: rtl/vftlc_pkg.sv
`include "vftlc_defs.svh"

package vftlc_pkg;

    typedef struct packed {
        logic [3:0] nzcv;
        logic cond_more;
        logic cond_last;
        logic cond_termination_absent_test;
        logic cond_termination_present_test;
        logic [2:0] fpctl;
        logic [4:0] trapctl;
        logic [3:0] len1;
        logic [3:0] len2;
        logic [3:0] len3;
        logic idc;
        logic flush_en;
        logic alt_fmt_eff;
        logic fp_exc;
        logic trap_raise;
        logic [5:0] syndrome;
        logic [31:0] restart_addr;
        logic [31:0] fault_addr;
        logic [4:0] eff_q;
        logic [31:0] rdata;
    } vftlc_state_t;

endpackage
